// ---- rtl/asc_defines.svh ----
// Constants for the address and status comparator self-test
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
`define ASC_AW 24
`define ASC_LIST_N 4
`define ASC_STAT_W 8
`define ASC_ERR_W 12
`define ASC_PA_W 12
// Register byte offsets
`define ASC_OFS_CTRL 12'h000
`define ASC_OFS_STATUS 12'h004
`define ASC_OFS_RESULT 12'h008
`define ASC_OFS_CUMUL 12'h00C
`define ASC_OFS_FAILS 12'h010
`define ASC_OFS_ITERS 12'h014
`define ASC_OFS_C1_LO 12'h018
`define ASC_OFS_C1_HI 12'h01C
`define ASC_OFS_C2_LO 12'h020
`define ASC_OFS_C2_HI 12'h024
`define ASC_OFS_PROBE 12'h028
`define ASC_OFS_INT_STAT 12'h02C
`define ASC_OFS_INT_CLR 12'h030
`define ASC_OFS_INT_EN 12'h034
`define ASC_OFS_MISS 12'h038
`define ASC_OFS_HIT 12'h03C
`define ASC_OFS_LIST 12'h040
`define ASC_OFS_EXST 12'h060
// Control and status bits
`define ASC_CTRL_RUN 0
`define ASC_ST_BUSY 0
`define ASC_ST_NOT_TESTED 1
`define ASC_ST_RELEASE 2
`define ASC_ST_NONE_CNT 3
`define ASC_MISS_NONE 31
`define ASC_INT_DONE 0
`define ASC_INT_ERR 1
// Error word field positions
`define ASC_E_C1 0
`define ASC_E_C2 2
`define ASC_E_DEC 4
`define ASC_E_PU 6
`define ASC_E_ARM 8
`define ASC_E_QUAL 10
`define ASC_E_SBUS 11
// Address test codes
`define ASC_AC_PASS 2'h0
`define ASC_AC_NONE 2'h1
`define ASC_AC_SOME 2'h2
`define ASC_AC_INVAL 2'h3
// Iteration time
`define ASC_ITER_TIME_MS 5000
`define ASC_CLK_KHZ 10000
`endif

// ---- rtl/asc_pkg.sv ----
// Types shared by the comparator self-test design
`include "asc_defines.svh"
package asc_pkg;
  typedef enum logic [6:0] {
    ASC_IDLE  = 7'h01,
    ASC_SELF1 = 7'h02,
    ASC_SELF2 = 7'h04,
    ASC_SELF3 = 7'h08,
    ASC_ADDR  = 7'h10,
    ASC_STAT  = 7'h20,
    ASC_DONE  = 7'h40
  } asc_fsm_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`ASC_PA_W-1:0] paddr;
    logic [31:0] pwdata;
  } asc_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } asc_apb_rsp_type;

  typedef struct packed {
    logic [`ASC_AW-1:0] addr;
    logic [`ASC_STAT_W-1:0] emulation_status_n;
    logic analysis_qualify_n;
  } asc_emu_bus_type;

  typedef struct packed {
    logic [`ASC_AW-1:0] sa1, sa2, sa3;
    logic [`ASC_STAT_W-1:0] ss1, ss2, ss3;
    logic sq1, sq2, sq3;
    asc_fsm_type fsm;
    logic run;
    logic [31:0] timer;
    logic [`ASC_AW-1:0] lo1, hi1, lo2, hi2, probe;
    logic [`ASC_LIST_N-1:0][`ASC_AW-1:0] lst;
    logic [`ASC_LIST_N-1:0][`ASC_STAT_W-1:0] exs;
    logic [`ASC_ERR_W-1:0] err, result, cumul;
    logic [31:0] fails, iters;
    logic not_tested, none_cnt;
    logic [`ASC_AW-1:0] miss_addr, hit_addr;
    logic [`ASC_LIST_N-1:0] stat_ok;
    logic [1:0] int_st, int_en;
    logic [31:0] prdata;
    logic pslverr;
  } asc_state_type;
endpackage

// ---- rtl/asc_range_cmp.sv ----
// One address range comparator that marks listed addresses it has counted
`timescale 1ns/1ps
`include "asc_defines.svh"
module asc_range_cmp #(
  parameter int AW = `ASC_AW,
  parameter int N = `ASC_LIST_N
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic count_en,
  input wire logic [AW-1:0] addr,
  input wire logic [AW-1:0] lo,
  input wire logic [AW-1:0] hi,
  input wire logic [N-1:0][AW-1:0] list,
  // Results
  output logic [N-1:0] found,
  output logic [N-1:0] in_range,
  output logic invalid
);
  typedef struct packed {
    logic [N-1:0] found;
    logic invalid;
  } asc_cmp_state_type;

  asc_cmp_state_type s_q, s_d;
  logic [N-1:0] hit;
  logic win;

  always_comb begin
    s_d = s_q;
    hit = '0;
    win = (addr >= lo) && (addr <= hi);
    for (int i = 0; i < N; i++) begin
      in_range[i] = (list[i] >= lo) && (list[i] <= hi);
      hit[i] = count_en && in_range[i] && (addr == list[i]);
    end
    if (clear) begin
      s_d.found = '0;
      s_d.invalid = 1'b0;
    end
    s_d.found = s_d.found | hit;
    // Counted in range but on no listed address
    if (count_en && win && (hit == '0)) begin
      s_d.invalid = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign found = s_q.found;
  assign invalid = s_q.invalid;
endmodule

// ---- rtl/asc_selftest.sv ----
// Self-test sequencer and error encoding for two address comparators
`timescale 1ns/1ps
`include "asc_defines.svh"
// Summary of operation
// - Comparator 1 result coded in two bits
// - Comparator 2 result coded the same way
// - Two decoder stuck-high flags, zero on pass
// - Two match-held-low flags, zero on pass
// - Two arming path flags, zero on pass
// - One status qualifier bit, one on fail
// - All fields packed in one error word
// - Each comparator reported separately in the error word, except the two shared arming flags; none counted and first miss/hit are shared
// - Load comparators, then release emulator to loop
// - Status check only after both comparators pass
// - Address and status paired in same cycle
// - Matched address with wrong status is fault
// - Address failure marks status test untested
// - Report none counted, or first miss/hit
// - Keep fail total, latest and cumulative codes
// - Iterate about five seconds, half that after an address failure, until stopped
module asc_selftest
  import asc_pkg::*;
#(
  parameter int unsigned ITER_CYCLES = `ASC_ITER_TIME_MS * `ASC_CLK_KHZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input asc_apb_req_type apb_req,
  output asc_apb_rsp_type apb_rsp,
  // Emulation bus, asynchronous
  input asc_emu_bus_type emu_bus,
  // Emulator control and interrupt
  output logic emu_release,
  output logic irq
);
  // Half an iteration for the address test, half for the status test
  localparam int unsigned PHASE_CYCLES = ITER_CYCLES / 2;
  localparam int N = `ASC_LIST_N;

  asc_state_type s_q, s_d;
  logic c_clear, c_en;
  logic [`ASC_AW-1:0] c_addr;
  logic [N-1:0] f1, f2, r1, r2, req;
  logic inv1, inv2, bus_ok, wr, setup;
  logic [1:0] code1, code2, int_set;
  logic [31:0] rd;
  logic rd_err;
  logic [`ASC_PA_W-1:0] pa;
  logic bus_stable;
  logic [N-1:0] seen;

  function automatic logic [1:0] acode(input logic [N-1:0] found,
                                       input logic [N-1:0] rng,
                                       input logic inv);
    logic [N-1:0] got;
    got = found & rng;
    if (got == rng) begin
      acode = `ASC_AC_PASS;
    end else if (got == '0) begin
      acode = inv ? `ASC_AC_INVAL : `ASC_AC_NONE;
    end else begin
      acode = `ASC_AC_SOME;
    end
  endfunction

  asc_range_cmp #(.AW(`ASC_AW), .N(N)) u_cmp1 (
    // Clock and reset
    .pclk(pclk),
    .presetn(presetn),
    // Control
    .clear(c_clear),
    .count_en(c_en),
    .addr(c_addr),
    .lo(s_q.lo1),
    .hi(s_q.hi1),
    .list(s_q.lst),
    // Results
    .found(f1),
    .in_range(r1),
    .invalid(inv1)
  );

  asc_range_cmp #(.AW(`ASC_AW), .N(N)) u_cmp2 (
    // Clock and reset
    .pclk(pclk),
    .presetn(presetn),
    // Control
    .clear(c_clear),
    .count_en(c_en),
    .addr(c_addr),
    .lo(s_q.lo2),
    .hi(s_q.hi2),
    .list(s_q.lst),
    // Results
    .found(f2),
    .in_range(r2),
    .invalid(inv2)
  );

  always_comb begin
    s_d = s_q;
    pa = apb_req.paddr;
    setup = apb_req.psel && !apb_req.penable;
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    int_set = 2'h0;
    req = r1 | r2;
    code1 = acode(f1, r1, inv1);
    code2 = acode(f2, r2, inv2);
    // Listed entries counted by the comparator whose window holds them
    seen = (f1 & r1) | (f2 & r2);
    c_clear = 1'b0;
    c_en = 1'b0;
    c_addr = s_q.sa2;
    rd = 32'h0000_0000;
    rd_err = 1'b0;

    // Emulation bus synchronisers
    s_d.sa1 = emu_bus.addr;
    s_d.sa2 = s_q.sa1;
    s_d.sa3 = s_q.sa2;
    s_d.ss1 = emu_bus.emulation_status_n;
    s_d.ss2 = s_q.ss1;
    s_d.ss3 = s_q.ss2;
    s_d.sq1 = emu_bus.analysis_qualify_n;
    s_d.sq2 = s_q.sq1;
    s_d.sq3 = s_q.sq2;
    // Bits are synchronised one by one, so a word caught while the
    // emulator changes it can be torn; use a sample only once it has
    // read the same on two edges in a row
    bus_stable = (s_q.sa2 == s_q.sa3) && (s_q.ss2 == s_q.ss3)
      && (s_q.sq2 == s_q.sq3);
    // Only qualified bus cycles are counted
    bus_ok = !s_q.sq2 && bus_stable;

    // Read decode, captured in the setup cycle
    case (pa)
      `ASC_OFS_CTRL: rd[`ASC_CTRL_RUN] = s_q.run;
      `ASC_OFS_STATUS: begin
        rd[`ASC_ST_BUSY] = (s_q.fsm != ASC_IDLE);
        rd[`ASC_ST_NOT_TESTED] = s_q.not_tested;
        rd[`ASC_ST_RELEASE] = emu_release;
        rd[`ASC_ST_NONE_CNT] = s_q.none_cnt;
      end
      `ASC_OFS_RESULT: rd[`ASC_ERR_W-1:0] = s_q.result;
      `ASC_OFS_CUMUL: rd[`ASC_ERR_W-1:0] = s_q.cumul;
      `ASC_OFS_FAILS: rd = s_q.fails;
      `ASC_OFS_ITERS: rd = s_q.iters;
      `ASC_OFS_C1_LO: rd[`ASC_AW-1:0] = s_q.lo1;
      `ASC_OFS_C1_HI: rd[`ASC_AW-1:0] = s_q.hi1;
      `ASC_OFS_C2_LO: rd[`ASC_AW-1:0] = s_q.lo2;
      `ASC_OFS_C2_HI: rd[`ASC_AW-1:0] = s_q.hi2;
      `ASC_OFS_PROBE: rd[`ASC_AW-1:0] = s_q.probe;
      `ASC_OFS_INT_STAT: rd[1:0] = s_q.int_st;
      `ASC_OFS_INT_CLR: rd = 32'h0000_0000;
      `ASC_OFS_INT_EN: rd[1:0] = s_q.int_en;
      `ASC_OFS_MISS: begin
        rd[`ASC_AW-1:0] = s_q.miss_addr;
        rd[`ASC_MISS_NONE] = s_q.none_cnt;
      end
      `ASC_OFS_HIT: rd[`ASC_AW-1:0] = s_q.hit_addr;
      // Unmapped offsets answer with an error and zero data
      default: begin
        rd_err = 1'b1;
        for (int i = 0; i < N; i++) begin
          if (pa == `ASC_OFS_LIST + `ASC_PA_W'(4 * i)) begin
            rd[`ASC_AW-1:0] = s_q.lst[i];
            rd_err = 1'b0;
          end
          if (pa == `ASC_OFS_EXST + `ASC_PA_W'(4 * i)) begin
            rd[`ASC_STAT_W-1:0] = s_q.exs[i];
            rd_err = 1'b0;
          end
        end
      end
    endcase
    // Captured in setup, so a register that moves during the access
    // phase still returns one consistent value
    if (setup) begin
      s_d.prdata = apb_req.pwrite ? 32'h0000_0000 : rd;
      s_d.pslverr = rd_err;
    end

    // Register writes take effect at the access edge
    if (wr && !rd_err) begin
      case (pa)
        `ASC_OFS_CTRL: begin
          s_d.run = apb_req.pwdata[`ASC_CTRL_RUN];
          // Starting a run drops the totals of the previous one
          if (apb_req.pwdata[`ASC_CTRL_RUN] && !s_q.run) begin
            s_d.cumul = '0;
            s_d.fails = 32'h0000_0000;
            s_d.iters = 32'h0000_0000;
          end
        end
        `ASC_OFS_C1_LO: s_d.lo1 = apb_req.pwdata[`ASC_AW-1:0];
        `ASC_OFS_C1_HI: s_d.hi1 = apb_req.pwdata[`ASC_AW-1:0];
        `ASC_OFS_C2_LO: s_d.lo2 = apb_req.pwdata[`ASC_AW-1:0];
        `ASC_OFS_C2_HI: s_d.hi2 = apb_req.pwdata[`ASC_AW-1:0];
        `ASC_OFS_PROBE: s_d.probe = apb_req.pwdata[`ASC_AW-1:0];
        `ASC_OFS_INT_CLR: s_d.int_st = s_q.int_st & ~apb_req.pwdata[1:0];
        `ASC_OFS_INT_EN: s_d.int_en = apb_req.pwdata[1:0];
        default: begin
          for (int i = 0; i < N; i++) begin
            if (pa == `ASC_OFS_LIST + `ASC_PA_W'(4 * i)) begin
              s_d.lst[i] = apb_req.pwdata[`ASC_AW-1:0];
            end
            if (pa == `ASC_OFS_EXST + `ASC_PA_W'(4 * i)) begin
              s_d.exs[i] = apb_req.pwdata[`ASC_STAT_W-1:0];
            end
          end
        end
      endcase
    end

    case (s_q.fsm)
      ASC_IDLE: begin
        if (s_q.run) begin
          s_d.fsm = ASC_SELF1;
        end
      end
      // Disarmed: a listed address must not be counted
      ASC_SELF1: begin
        s_d.err = '0;
        c_addr = s_q.lst[0];
        c_clear = 1'b1;
        s_d.fsm = ASC_SELF2;
      end
      // Armed on an unlisted probe: no decoder output may fire
      ASC_SELF2: begin
        s_d.err[`ASC_E_ARM] = (f1 != '0) || (f2 != '0);
        c_addr = s_q.probe;
        c_clear = 1'b1;
        c_en = 1'b1;
        s_d.fsm = ASC_SELF3;
      end
      // Armed on the first listed address: its match must rise
      ASC_SELF3: begin
        s_d.err[`ASC_E_DEC] = (f1 != '0);
        s_d.err[`ASC_E_DEC+1] = (f2 != '0);
        c_addr = s_q.lst[0];
        c_clear = 1'b1;
        c_en = 1'b1;
        s_d.timer = 32'h0000_0000;
        s_d.fsm = ASC_ADDR;
      end
      ASC_ADDR: begin
        c_en = bus_ok;
        if (s_q.timer == 32'h0000_0000) begin
          // Drop whatever the self-test steps left in the comparators
          c_clear = 1'b1;
          s_d.err[`ASC_E_PU] = r1[0] && !f1[0];
          s_d.err[`ASC_E_PU+1] = r2[0] && !f2[0];
          s_d.err[`ASC_E_ARM+1] = req[0] && !f1[0] && !f2[0];
        end
        s_d.timer = s_q.timer + 32'h0000_0001;
        if (s_q.timer == PHASE_CYCLES - 1) begin
          s_d.timer = 32'h0000_0000;
          s_d.err[`ASC_E_C1 +: 2] = code1;
          s_d.err[`ASC_E_C2 +: 2] = code2;
          // Report flags hold until the next address test ends, so
          // software can still read them after the interrupt
          s_d.none_cnt = (seen == '0);
          s_d.miss_addr = '0;
          s_d.hit_addr = '0;
          // First expected address missed, first one found
          for (int i = N - 1; i >= 0; i--) begin
            if (req[i] && !seen[i]) begin
              s_d.miss_addr = s_q.lst[i];
            end
            if (seen[i]) begin
              s_d.hit_addr = s_q.lst[i];
            end
          end
          if (code1 == `ASC_AC_PASS && code2 == `ASC_AC_PASS) begin
            s_d.not_tested = 1'b0;
            s_d.stat_ok = '0;
            s_d.fsm = ASC_STAT;
          end else begin
            s_d.not_tested = 1'b1;
            s_d.fsm = ASC_DONE;
          end
        end
      end
      // A pair counts only when address and code match together
      ASC_STAT: begin
        if (bus_ok) begin
          for (int i = 0; i < N; i++) begin
            if (req[i] && s_q.sa2 == s_q.lst[i]) begin
              if (~s_q.ss2 == s_q.exs[i]) begin
                s_d.stat_ok[i] = 1'b1;
              end else begin
                s_d.err[`ASC_E_QUAL] = 1'b1;
              end
            end
          end
        end
        s_d.timer = s_q.timer + 32'h0000_0001;
        if (s_q.timer == PHASE_CYCLES - 1) begin
          s_d.err[`ASC_E_SBUS] = (s_q.stat_ok & req) != req;
          s_d.fsm = ASC_DONE;
        end
      end
      ASC_DONE: begin
        // Latest and cumulative codes move on the same edge
        s_d.result = s_q.err;
        s_d.cumul = s_q.cumul | s_q.err;
        s_d.iters = s_q.iters + 32'h0000_0001;
        if (s_q.err != '0) begin
          s_d.fails = s_q.fails + 32'h0000_0001;
        end
        int_set[`ASC_INT_DONE] = 1'b1;
        int_set[`ASC_INT_ERR] = (s_q.err != '0);
        s_d.fsm = s_q.run ? ASC_SELF1 : ASC_IDLE;
      end
      default: s_d.fsm = ASC_IDLE;
    endcase

    // A new event outranks a clear in the same cycle
    s_d.int_st = s_d.int_st | int_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.fsm <= ASC_IDLE;
      // Qualify idles high, so its synchronisers reset to that level
      s_q.sq1 <= 1'b1;
      s_q.sq2 <= 1'b1;
      s_q.sq3 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Emulator loops only during the two bus phases
  assign emu_release = (s_q.fsm == ASC_ADDR) || (s_q.fsm == ASC_STAT);
  // Level interrupt from sticky status and enable
  assign irq = (s_q.int_st & s_q.int_en) != 2'h0;
  // Zero wait states on the register bus
  assign apb_rsp.prdata = s_q.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && s_q.pslverr;
endmodule

// ---- tb/asc_selftest_assertions.sv ----
// Port checks for the comparator self-test block
`timescale 1ns/1ps
module asc_selftest_checker
  import asc_pkg::*;
#(
  parameter int unsigned ITER_CYCLES = 200
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input asc_apb_req_type apb_req,
  input asc_apb_rsp_type apb_rsp,
  // Emulator side
  input asc_emu_bus_type emu_bus,
  input wire logic emu_release,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] rel_cnt_q;
  logic acc;
  assign acc = apb_req.psel && apb_req.penable;
  // Length of the current release window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_cnt_q <= 32'h0;
    end else begin
      rel_cnt_q <= emu_release ? rel_cnt_q + 32'h1 : 32'h0;
    end
  end
  property p_ready;
    apb_rsp.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_unmapped;
    acc && apb_req.paddr == 12'h050 |-> apb_rsp.pslverr
      && apb_rsp.prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access");
  property p_mapped;
    acc && apb_req.paddr == 12'h000 |-> !apb_rsp.pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped error");
  property p_clr_rd0;
    acc && !apb_req.pwrite && apb_req.paddr == 12'h030 |->
      apb_rsp.prdata == 32'h0;
  endproperty
  a_clr_rd0: assert property (p_clr_rd0) else $error("clear reg read");
  property p_rel_hold;
    $rose(emu_release) |-> emu_release[*8];
  endproperty
  a_rel_hold: assert property (p_rel_hold) else $error("short release");
  property p_rel_len;
    $fell(emu_release) |-> rel_cnt_q == ITER_CYCLES / 2
      || rel_cnt_q == ITER_CYCLES;
  endproperty
  a_rel_len: assert property (p_rel_len) else $error("phase length");
  property p_rel_max;
    rel_cnt_q <= ITER_CYCLES;
  endproperty
  a_rel_max: assert property (p_rel_max) else $error("release too long");
  property p_rel_gap;
    $fell(emu_release) |-> !emu_release[*4];
  endproperty
  a_rel_gap: assert property (p_rel_gap) else $error("release gap");
  property p_irq_rise;
    $rose(irq) |-> !emu_release
      || $past(apb_req.penable && apb_req.pwrite);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq early");
endmodule

bind asc_selftest asc_selftest_checker #(.ITER_CYCLES(ITER_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .emu_bus(emu_bus), .emu_release(emu_release), .irq(irq));

// ---- tb/asc_emu_model.sv ----
// Emulator model looping the stimulus program on the emulation bus
`timescale 1ns/1ps
`include "asc_defines.svh"
module asc_emu_model
  import asc_pkg::*;
(
  // Clock and release
  input wire logic pclk,
  input wire logic emu_release,
  // Program lists and fault mode
  input wire logic [`ASC_LIST_N-1:0][`ASC_AW-1:0] lst,
  input wire logic [`ASC_LIST_N-1:0][`ASC_STAT_W-1:0] sts,
  input wire logic [2:0] mode,
  // Emulation bus
  output asc_emu_bus_type emu_bus
);
  logic [4:0] cnt_q = 5'h00;
  logic [2:0] idx;
  assign idx = cnt_q[4:2];
  initial emu_bus = '1;
  // Each listed cycle held three clocks, then one idle clock
  always @(posedge pclk) begin
    cnt_q <= emu_release ? cnt_q + 5'h01 : 5'h00;
    if (emu_release && idx < 3'h4 && cnt_q[1:0] != 2'h3) begin
      emu_bus.addr <= lst[idx[1:0]] + {23'h0, mode == 3'h4};
      emu_bus.emulation_status_n <= ~(sts[idx[1:0]] ^ {7'h0, mode == 3'h1});
      emu_bus.analysis_qualify_n <= mode == 3'h2
        || (mode == 3'h3 && idx == 3'h3);
    end else begin
      emu_bus.addr <= ~emu_bus.addr;
      emu_bus.emulation_status_n <= ~emu_bus.emulation_status_n;
      emu_bus.analysis_qualify_n <= 1'b1;
    end
  end
endmodule

// ---- tb/test_address_status_comparator_selftest.sv ----
// Self-checking bench for the comparator self-test block
`timescale 1ns/1ps
`include "asc_defines.svh"
module test_address_status_comparator_selftest;
  import asc_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  asc_apb_req_type apb_req = '0;
  asc_apb_rsp_type apb_rsp;
  asc_emu_bus_type emu_bus;
  logic emu_release, irq, err;
  logic [2:0] mode = 3'h0;
  logic [3:0][23:0] lst = {24'h40, 24'h32, 24'h10, 24'h04};
  logic [3:0][7:0] sts = {8'h5A, 8'hC3, 8'h96, 8'h3C};
  logic [11:0] res_exp [5] = '{12'h000, 12'hC00, 12'h005, 12'h008, 12'h00F};
  logic [11:0] res_msk [5] = '{12'hFFF, 12'hFFF, 12'hC0F, 12'hFFF, 12'hC0F};
  logic [31:0] rd;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  always #50 pclk = ~pclk;
  asc_selftest #(.ITER_CYCLES(200)) uut (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .emu_bus(emu_bus),
    .emu_release(emu_release), .irq(irq));
  asc_emu_model emu (.pclk(pclk), .emu_release(emu_release), .lst(lst),
    .sts(sts), .mode(mode), .emu_bus(emu_bus));
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, e, rd & m);
  endtask
  task automatic wrap_up;
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    int n;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("release idle", 0, emu_release);
    rdchk(`ASC_OFS_RESULT, 32'hFFF, 0, "result reset");
    rdchk(`ASC_OFS_INT_EN, 32'h3, 0, "int_en reset");
    apb(1'b0, 12'h050, 32'h0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    apb(1'b1, `ASC_OFS_RESULT, 32'hFFF);
    rdchk(`ASC_OFS_RESULT, 32'hFFF, 0, "result read-only");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `ASC_OFS_LIST + 12'(4 * i), {8'h0, lst[i]});
      apb(1'b1, `ASC_OFS_EXST + 12'(4 * i), {24'h0, sts[i]});
    end
    apb(1'b1, `ASC_OFS_C1_LO, 32'h0);
    apb(1'b1, `ASC_OFS_C1_HI, 32'h1F);
    apb(1'b1, `ASC_OFS_C2_LO, 32'h20);
    apb(1'b1, `ASC_OFS_C2_HI, 32'hFF);
    apb(1'b1, `ASC_OFS_PROBE, 32'h80);
    apb(1'b1, `ASC_OFS_INT_EN, 32'h3);
    rdchk(`ASC_OFS_C1_HI, 32'hFFFFFF, 32'h1F, "c1 hi");
    apb(1'b1, `ASC_OFS_CTRL, 32'h1);
    // Good, wrong status, no qualify, partial, only invalid
    for (int k = 0; k < 5; k++) begin
      n = 0;
      while (irq !== 1'b1 && n < 800) begin
        @(posedge pclk);
        n++;
      end
      chk("irq", 1, irq);
      mode <= (k == 4) ? 3'h0 : 3'(k + 1);
      rdchk(`ASC_OFS_INT_STAT, 3, (k == 0) ? 1 : 3, "int_stat");
      apb(1'b1, `ASC_OFS_INT_CLR, 32'h3);
      chk("irq cleared", 0, irq);
      rdchk(`ASC_OFS_RESULT, res_msk[k], res_exp[k], "result");
      if (k == 2) begin
        rdchk(`ASC_OFS_STATUS, 32'hA, 32'hA, "not tested");
        rdchk(`ASC_OFS_MISS, 32'h80000000, 32'h80000000, "none");
      end
      if (k == 3) begin
        rdchk(`ASC_OFS_MISS, 32'hFFFFFF, 32'h40, "first miss");
        rdchk(`ASC_OFS_HIT, 32'hFFFFFF, 32'h04, "first hit");
      end
    end
    apb(1'b1, `ASC_OFS_CTRL, 32'h0);
    n = 0;
    do begin
      apb(1'b0, `ASC_OFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    chk("stopped", 0, rd[0]);
    rdchk(`ASC_OFS_STATUS, 32'hA, 32'h0, "tested again");
    rdchk(`ASC_OFS_FAILS, '1, 4, "fails");
    rdchk(`ASC_OFS_ITERS, '1, 6, "iters");
    rdchk(`ASC_OFS_CUMUL, 32'hC0F, 32'hC0F, "cumul");
    apb(1'b1, `ASC_OFS_INT_EN, 32'h0);
    chk("irq masked", 0, irq);
    apb(1'b1, `ASC_OFS_INT_EN, 32'h3);
    chk("irq unmasked", 1, irq);
    apb(1'b1, `ASC_OFS_CTRL, 32'h1);
    rdchk(`ASC_OFS_CUMUL, '1, 0, "cumul restart");
    rdchk(`ASC_OFS_FAILS, '1, 0, "fails restart");
    apb(1'b1, `ASC_OFS_CTRL, 32'h0);
    wrap_up();
  end
endmodule
